// ===== sowc_cfg.sv
// system option registers with write-once watchdog configuration
//
// Function
// R1: two-bit watchdog timeout field, option1 bits 7:6
// R2: code zero disables; bus overflow 2^13/2^16/2^18
// R3: 1 kHz overflow after 2^5/2^8/2^10 ticks
// R4: bus-clock window opens at 6144/49152/196608 counts
// R5: software services only in final quarter
// R6: windowed: early reset-status write resets device
// R7: option2 bit 6 write-once window mode
// R8: option2 bit 7 write-once clock select
// R9: option1 bit 5 write-once stop allow
// R10: stop while disallowed forces illegal-opcode reset
// R11: option1 bit 3 write-once two-wire pin location
// R12: option2 bit 4 converter trigger source select
// R13: nonzero divider outputs bus clock over 2N
// R14: zero divider keeps clock output disabled
// R15: option2 write-once bits take first write only
// R16: read-only 12-bit part code over two registers
// R17: high id upper nibble is hard revision
// R18: option1 takes first write only, always readable
// R19: 0x55 then 0xAA clears watchdog counter
// R20: other value to reset-status causes watchdog reset
// R21: counter restarts on service, overflow requests reset
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/100ps

module sowc_cfg #(
	parameter logic [11:0] PART_CODE = 12'h5A3,	// arbitrary value
	parameter logic [3:0]  REVISION  = 4'h1	// arbitrary value
) (
	input  wire logic                  MCLK,
	input  wire logic                  RST_N,
	input  wire logic                  CE,
	input  wire sowc_pkg::sowc_bus_req_t BUS_REQ,
	output logic [7:0]                 RDATA,
	input  wire logic                  LPO_TICK,
	input  wire logic                  STOP_REQ,
	output logic                       STOP_ENTER,
	output logic                       ILLEGAL_OP_RST,
	output logic                       WDOG_RST,
	output logic                       TWOWIRE_ON_PORT_E,
	input  wire logic                  CONV_HW_TRIGGER_ON,
	input  wire logic                  RTC_OVERFLOW,
	input  wire logic                  IRQ_PIN_EVENT,
	output logic                       CONV_HW_TRIGGER,
	output logic                       PORT_A_BIT0_OUT,
	output logic                       PORT_A_BIT0_OE
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// service sequence progress
	typedef enum logic [0:0] {
		SVC_IDLE,
		SVC_ARMED
	} sowc_svc_t;

	typedef struct packed {
		logic [7:0]                      opt1;
		logic                            opt1_done;
		logic [7:0]                      opt2;
		logic                            opt2_done;
		// one bit wider than the longest overflow count, so 2^18 fits
		logic [sowc_pkg::WDOG_CNT_W-1:0] wd_cnt;
		sowc_svc_t                       svc;
		logic                            wd_rst;
		logic                            ilop_rst;
		logic                            stop_go;
		logic [7:0]                      rdata;
		logic [2:0]                      div_cnt;
		logic                            clk_out;
		logic                            trig;
	} sowc_state_t;

	sowc_state_t st_q;
	sowc_state_t st_d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// overflow count for a timeout code and count source; zero when off
	function automatic logic [sowc_pkg::WDOG_CNT_W-1:0] overflow_limit(
		input logic       bus_clk,
		input logic [1:0] code
	);
		logic [sowc_pkg::WDOG_CNT_W-1:0] lim;
		lim = '0;
		if (bus_clk) begin
			case (code)
				2'h1:    lim = sowc_pkg::BUS_LIMIT_1;
				2'h2:    lim = sowc_pkg::BUS_LIMIT_2;
				2'h3:    lim = sowc_pkg::BUS_LIMIT_3;
				default: lim = '0;
			endcase
		end else begin
			case (code)
				2'h1:    lim = sowc_pkg::LPO_LIMIT_1;
				2'h2:    lim = sowc_pkg::LPO_LIMIT_2;
				2'h3:    lim = sowc_pkg::LPO_LIMIT_3;
				default: lim = '0;
			endcase
		end
		return lim;
	endfunction : overflow_limit

	// first count at which a windowed service is legal
	function automatic logic [sowc_pkg::WDOG_CNT_W-1:0] window_open(
		input logic [1:0] code
	);
		logic [sowc_pkg::WDOG_CNT_W-1:0] w;
		w = '0;
		case (code)
			2'h1:    w = sowc_pkg::WINDOW_OPEN_1;
			2'h2:    w = sowc_pkg::WINDOW_OPEN_2;
			2'h3:    w = sowc_pkg::WINDOW_OPEN_3;
			default: w = '0;
		endcase
		return w;
	endfunction : window_open

	// masked write that keeps frozen bits at their stored value
	function automatic logic [7:0] guarded_write(
		input logic [7:0] old_val,
		input logic [7:0] new_val,
		input logic [7:0] impl_mask,
		input logic [7:0] frozen_mask
	);
		logic [7:0] v;
		v = new_val & impl_mask;
		v = (v & ~frozen_mask) | (old_val & frozen_mask);
		return v;
	endfunction : guarded_write

	// register read mux; unmapped and write-only addresses read zero
	function automatic logic [7:0] read_value(
		input logic [7:0] addr,
		input logic [7:0] opt1,
		input logic [7:0] opt2
	);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			sowc_pkg::OFS_SYSTEM_OPTIONS_1: v = opt1; // [R18]
			sowc_pkg::OFS_SYSTEM_OPTIONS_2: v = opt2;
			sowc_pkg::OFS_PART_ID_HIGH:     v = {REVISION, PART_CODE[11:8]}; // [R16] [R17]
			sowc_pkg::OFS_PART_ID_LOW:      v = PART_CODE[7:0]; // [R16]
			default:                        v = 8'h00;
		endcase
		return v;
	endfunction : read_value

	// one strobe aimed at one register address
	function automatic logic addr_hit(
		input logic       strobe,
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return strobe && (addr == ofs);
	endfunction : addr_hit

	// converter trigger; the source select only matters while enabled
	function automatic logic trigger_select(
		input logic enable,
		input logic use_irq,
		input logic rtc_ovf,
		input logic irq_evt
	);
		logic t;
		t = 1'b0;
		if (enable) begin
			t = use_irq ? irq_evt : rtc_ovf;
		end
		return t;
	endfunction : trigger_select

	// ----------------------------------------------------------------
	// decoded fields
	// ----------------------------------------------------------------
	// watchdog
	logic [1:0]                      timeout_sel;
	logic                            clock_sel;
	logic                            window_mode;
	logic                            wd_enabled;
	logic                            wd_step;
	logic [sowc_pkg::WDOG_CNT_W-1:0] wd_limit;
	logic [sowc_pkg::WDOG_CNT_W-1:0] wd_last;
	logic                            wd_expired;
	logic                            win_closed;

	// register bus
	logic                            wr_opt1;
	logic                            wr_opt2;
	logic                            wr_srs;
	logic [7:0]                      opt2_frozen;

	// clock output
	logic [2:0]                      divider;
	logic                            clkout_wrap;

	always_comb begin
		timeout_sel = st_q.opt1[sowc_pkg::WDOG_TIMEOUT_SEL_HI:sowc_pkg::WDOG_TIMEOUT_SEL_LO]; // [R1]
		clock_sel   = st_q.opt2[sowc_pkg::WDOG_CLOCK_SEL_BIT]; // [R8]
		window_mode = st_q.opt2[sowc_pkg::WDOG_WINDOW_MODE_BIT]; // [R7]
		wd_enabled  = (timeout_sel != 2'h0); // [R2]
		wd_step     = wd_enabled && (clock_sel || LPO_TICK); // [R3]
		wd_limit    = overflow_limit(clock_sel, timeout_sel); // [R2] [R3]
		wd_last     = wd_limit - {{(sowc_pkg::WDOG_CNT_W-1){1'b0}}, 1'b1};
		wd_expired  = wd_step && (st_q.wd_cnt >= wd_last); // [R21]
		// the window only exists with the bus clock as count source
		win_closed  = window_mode && clock_sel
			&& (st_q.wd_cnt < window_open(timeout_sel)); // [R4]
		wr_opt1     = addr_hit(BUS_REQ.wr, BUS_REQ.addr, sowc_pkg::OFS_SYSTEM_OPTIONS_1);
		wr_opt2     = addr_hit(BUS_REQ.wr, BUS_REQ.addr, sowc_pkg::OFS_SYSTEM_OPTIONS_2);
		wr_srs      = addr_hit(BUS_REQ.wr, BUS_REQ.addr, sowc_pkg::OFS_RESET_STATUS_REG);
		opt2_frozen = st_q.opt2_done ? sowc_pkg::SYSTEM_OPTIONS_2_ONCE : 8'h00; // [R15]
		divider     = st_q.opt2[sowc_pkg::CLKOUT_DIVIDER_HI:sowc_pkg::CLKOUT_DIVIDER_LO];
		clkout_wrap = (st_q.div_cnt >= divider - 3'h1);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d          = st_q;
		st_d.wd_rst   = 1'b0;
		st_d.ilop_rst = 1'b0;
		st_d.stop_go  = 1'b0;
		st_d.rdata    = 8'h00;

		// ------------------------------------------------------------
		// option writes; option 1 locks whole, option 2 its once-bits
		// ------------------------------------------------------------
		if (wr_opt1 && !st_q.opt1_done) begin
			st_d.opt1      = guarded_write(st_q.opt1, BUS_REQ.wdata,
				sowc_pkg::SYSTEM_OPTIONS_1_MASK, 8'h00); // [R18] [R9] [R11]
			st_d.opt1_done = 1'b1; // [R18]
		end
		if (wr_opt2) begin
			st_d.opt2      = guarded_write(st_q.opt2, BUS_REQ.wdata,
				sowc_pkg::SYSTEM_OPTIONS_2_MASK, opt2_frozen); // [R7] [R8] [R12] [R15]
			st_d.opt2_done = 1'b1; // [R15]
		end

		// ------------------------------------------------------------
		// read data, one cycle after the strobe
		// ------------------------------------------------------------
		if (BUS_REQ.rd) begin
			st_d.rdata = read_value(BUS_REQ.addr, st_q.opt1, st_q.opt2); // [R16]
		end

		// ------------------------------------------------------------
		// watchdog count and overflow
		// ------------------------------------------------------------
		if (wd_step) begin
			if (wd_expired) begin
				st_d.wd_cnt = '0;
				st_d.wd_rst = 1'b1; // [R21] [R2] [R3]
			end else begin
				st_d.wd_cnt = st_q.wd_cnt + {{(sowc_pkg::WDOG_CNT_W-1){1'b0}}, 1'b1};
			end
		end
		if (!wd_enabled) begin
			st_d.wd_cnt = '0; // [R2]
			st_d.svc    = SVC_IDLE;
		end

		// ------------------------------------------------------------
		// service sequence and its violations
		// ------------------------------------------------------------
		if (wr_srs && wd_enabled) begin
			if (win_closed) begin
				// early write in window mode
				st_d.wd_rst = 1'b1; // [R6] [R4] [R5]
				st_d.wd_cnt = '0;
				st_d.svc    = SVC_IDLE;
			end else begin
				case (st_q.svc)
					SVC_IDLE: begin
						if (BUS_REQ.wdata == sowc_pkg::SERVICE_FIRST) begin
							st_d.svc = SVC_ARMED; // [R19]
						end else if (BUS_REQ.wdata != sowc_pkg::SERVICE_SECOND) begin
							st_d.wd_rst = 1'b1; // [R20]
							st_d.wd_cnt = '0;
						end
					end
					SVC_ARMED: begin
						if (BUS_REQ.wdata == sowc_pkg::SERVICE_SECOND) begin
							st_d.wd_cnt = '0; // [R19] [R21]
							st_d.wd_rst = 1'b0;
							st_d.svc    = SVC_IDLE;
						end else if (BUS_REQ.wdata != sowc_pkg::SERVICE_FIRST) begin
							st_d.wd_rst = 1'b1; // [R20]
							st_d.wd_cnt = '0;
							st_d.svc    = SVC_IDLE;
						end
					end
					default: begin
						st_d.svc = SVC_IDLE;
					end
				endcase
			end
		end

		// ------------------------------------------------------------
		// stop instruction check
		// ------------------------------------------------------------
		if (STOP_REQ) begin
			if (st_q.opt1[sowc_pkg::STOP_ALLOW_BIT]) begin
				st_d.stop_go = 1'b1; // [R9]
			end else begin
				st_d.ilop_rst = 1'b1; // [R10]
			end
		end

		// ------------------------------------------------------------
		// converter trigger routing
		// ------------------------------------------------------------
		st_d.trig = trigger_select(CONV_HW_TRIGGER_ON, st_q.opt2[sowc_pkg::CONV_TRIG_SRC_BIT],
			RTC_OVERFLOW, IRQ_PIN_EVENT); // [R12]

		// ------------------------------------------------------------
		// divided clock: toggles every N bus cycles, so period is 2N
		// ------------------------------------------------------------
		if (divider == 3'h0) begin
			st_d.div_cnt = 3'h0;
			st_d.clk_out = 1'b0; // [R14]
		end else if (clkout_wrap) begin
			st_d.div_cnt = 3'h0;
			st_d.clk_out = ~st_q.clk_out; // [R13]
		end else begin
			st_d.div_cnt = st_q.div_cnt + 3'h1; // [R13]
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q.opt1      <= sowc_pkg::SYSTEM_OPTIONS_1_RST;
			st_q.opt1_done <= 1'b0;
			st_q.opt2      <= sowc_pkg::SYSTEM_OPTIONS_2_RST;
			st_q.opt2_done <= 1'b0;
			st_q.wd_cnt    <= '0;
			st_q.svc       <= SVC_IDLE;
			st_q.wd_rst    <= 1'b0;
			st_q.ilop_rst  <= 1'b0;
			st_q.stop_go   <= 1'b0;
			st_q.rdata     <= 8'h00;
			st_q.div_cnt   <= 3'h0;
			st_q.clk_out   <= 1'b0;
			st_q.trig      <= 1'b0;
		end else if (CE) begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// register outputs
	// ----------------------------------------------------------------
	always_comb begin
		RDATA           = st_q.rdata;
		WDOG_RST        = st_q.wd_rst;
		ILLEGAL_OP_RST  = st_q.ilop_rst;
		STOP_ENTER      = st_q.stop_go;
		CONV_HW_TRIGGER = st_q.trig;
	end

	// ----------------------------------------------------------------
	// pin routing outputs
	// ----------------------------------------------------------------
	always_comb begin
		TWOWIRE_ON_PORT_E = st_q.opt1[sowc_pkg::TWOWIRE_PIN_LOC_BIT]; // [R11]
		PORT_A_BIT0_OUT   = st_q.clk_out;
		PORT_A_BIT0_OE    = (divider != 3'h0); // [R13] [R14]
	end

endmodule : sowc_cfg

// ===== sowc_pkg.sv
// package: register map, field layout, reset values and watchdog counts
package sowc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SYSTEM_OPTIONS_1 = 8'h00;
	localparam logic [7:0] OFS_SYSTEM_OPTIONS_2 = 8'h01;
	localparam logic [7:0] OFS_PART_ID_HIGH     = 8'h02;
	localparam logic [7:0] OFS_PART_ID_LOW      = 8'h03;
	localparam logic [7:0] OFS_RESET_STATUS_REG = 8'h04;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int WDOG_TIMEOUT_SEL_HI   = 7;
	localparam int WDOG_TIMEOUT_SEL_LO   = 6;
	localparam int STOP_ALLOW_BIT        = 5;
	localparam int TWOWIRE_PIN_LOC_BIT   = 3;
	localparam int WDOG_CLOCK_SEL_BIT    = 7;
	localparam int WDOG_WINDOW_MODE_BIT  = 6;
	localparam int CONV_TRIG_SRC_BIT     = 4;
	localparam int CLKOUT_DIVIDER_HI     = 2;
	localparam int CLKOUT_DIVIDER_LO     = 0;

	// implemented bits; the rest read as zero
	localparam logic [7:0] SYSTEM_OPTIONS_1_MASK = 8'hE8;
	localparam logic [7:0] SYSTEM_OPTIONS_2_MASK = 8'hD7;
	// write-once bits of the second option register
	localparam logic [7:0] SYSTEM_OPTIONS_2_ONCE = 8'hC0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SYSTEM_OPTIONS_1_RST = 8'h00;
	localparam logic [7:0] SYSTEM_OPTIONS_2_RST = 8'h00;

	// ----------------------------------------------------------------
	// service sequence bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] SERVICE_FIRST  = 8'h55;
	localparam logic [7:0] SERVICE_SECOND = 8'hAA;

	// ----------------------------------------------------------------
	// watchdog counts
	// ----------------------------------------------------------------
	localparam int          WDOG_CNT_W     = 19;
	localparam logic [18:0] BUS_LIMIT_1    = 19'h02000;
	localparam logic [18:0] BUS_LIMIT_2    = 19'h10000;
	localparam logic [18:0] BUS_LIMIT_3    = 19'h40000;
	localparam logic [18:0] LPO_LIMIT_1    = 19'h00020;
	localparam logic [18:0] LPO_LIMIT_2    = 19'h00100;
	localparam logic [18:0] LPO_LIMIT_3    = 19'h00400;
	localparam logic [18:0] WINDOW_OPEN_1  = 19'h01800;
	localparam logic [18:0] WINDOW_OPEN_2  = 19'h0C000;
	localparam logic [18:0] WINDOW_OPEN_3  = 19'h30000;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sowc_bus_req_t;

endpackage : sowc_pkg

// ===== sowc_cfg_properties.sv
// checker: port-level properties of the system option register block
`timescale 1ns/100ps

module sowc_cfg_properties #(
	parameter logic [11:0] PART_CODE = 12'h5A3,	// arbitrary value
	parameter logic [3:0]  REVISION  = 4'h1	// arbitrary value
) (
	input wire logic                    MCLK,
	input wire logic                    RST_N,
	input wire logic                    CE,
	input wire sowc_pkg::sowc_bus_req_t BUS_REQ,
	input wire logic [7:0]              RDATA,
	input wire logic                    STOP_REQ,
	input wire logic                    STOP_ENTER,
	input wire logic                    ILLEGAL_OP_RST,
	input wire logic                    WDOG_RST,
	input wire logic                    CONV_HW_TRIGGER_ON,
	input wire logic                    RTC_OVERFLOW,
	input wire logic                    IRQ_PIN_EVENT,
	input wire logic                    CONV_HW_TRIGGER,
	input wire logic                    PORT_A_BIT0_OUT,
	input wire logic                    PORT_A_BIT0_OE
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_stop_one; CE && STOP_REQ |=> STOP_ENTER != ILLEGAL_OP_RST; endproperty
	a_stop_one: assert property (p_stop_one)
		else $error("stop request not answered exactly once");
	property p_stop_cause; (STOP_ENTER || ILLEGAL_OP_RST) |-> $past(STOP_REQ); endproperty
	a_stop_cause: assert property (p_stop_cause)
		else $error("stop answer without request");
	property p_rd_idle; !$past(BUS_REQ.rd) |-> RDATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	property p_id_low;
		CE && BUS_REQ.rd && BUS_REQ.addr == sowc_pkg::OFS_PART_ID_LOW |=> RDATA == PART_CODE[7:0];
	endproperty
	a_id_low: assert property (p_id_low)
		else $error("low id wrong");
	property p_id_high; CE && BUS_REQ.rd && BUS_REQ.addr == sowc_pkg::OFS_PART_ID_HIGH
		|=> RDATA == {REVISION, PART_CODE[11:8]}; endproperty
	a_id_high: assert property (p_id_high)
		else $error("high id wrong");
	property p_trig; CONV_HW_TRIGGER |-> $past(CONV_HW_TRIGGER_ON)
		&& ($past(RTC_OVERFLOW) || $past(IRQ_PIN_EVENT)); endproperty
	a_trig: assert property (p_trig)
		else $error("converter trigger without enabled source");
	// out may settle one cycle after the divider is cleared
	property p_clkout; $changed(PORT_A_BIT0_OUT) |-> $past(PORT_A_BIT0_OE) || $past(PORT_A_BIT0_OE, 2);
	endproperty
	a_clkout: assert property (p_clkout)
		else $error("clock output moves while disabled");
	property p_wdog_pulse; WDOG_RST |=> !WDOG_RST; endproperty
	a_wdog_pulse: assert property (p_wdog_pulse)
		else $error("watchdog reset longer than one cycle");

	c_wdog: cover property (WDOG_RST);
	c_illegal: cover property (ILLEGAL_OP_RST);
	c_clkout: cover property (PORT_A_BIT0_OE && $changed(PORT_A_BIT0_OUT));
endmodule : sowc_cfg_properties

bind sowc_cfg sowc_cfg_properties #(.PART_CODE(PART_CODE), .REVISION(REVISION)) u_props (
	.MCLK, .RST_N, .CE, .BUS_REQ, .RDATA, .STOP_REQ, .STOP_ENTER, .ILLEGAL_OP_RST, .WDOG_RST,
	.CONV_HW_TRIGGER_ON, .RTC_OVERFLOW, .IRQ_PIN_EVENT, .CONV_HW_TRIGGER,
	.PORT_A_BIT0_OUT, .PORT_A_BIT0_OE
);

// ===== test_sowc_cfg.sv
// testbench: registers, stop, trigger, clock output and watchdog
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_sowc_cfg;
	localparam logic [11:0] PC = 12'h5A3;	// arbitrary value
	logic                    mclk = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    lpo_tick = 1'b0;
	logic                    stop_req = 1'b0;
	logic                    trig_on = 1'b0;
	logic                    rtc_ovf = 1'b0;
	logic                    irq_evt = 1'b0;
	sowc_pkg::sowc_bus_req_t req = '0;
	logic [7:0]              rdata;
	logic                    stop_enter, ill_rst, wdog_rst, on_e, conv_trig, clk_out, clk_oe;
	int                      err_count = 0;
	int                      comparisons = 0;
	int                      wd_n = 0;
	time                     t0;

	sowc_cfg #(.PART_CODE(PC), .REVISION(4'h1)) uut (.MCLK(mclk), .RST_N(rst_n), .CE(1'b1),
		.BUS_REQ(req), .RDATA(rdata), .LPO_TICK(lpo_tick), .STOP_REQ(stop_req),
		.STOP_ENTER(stop_enter), .ILLEGAL_OP_RST(ill_rst), .WDOG_RST(wdog_rst),
		.TWOWIRE_ON_PORT_E(on_e), .CONV_HW_TRIGGER_ON(trig_on), .RTC_OVERFLOW(rtc_ovf),
		.IRQ_PIN_EVENT(irq_evt), .CONV_HW_TRIGGER(conv_trig), .PORT_A_BIT0_OUT(clk_out),
		.PORT_A_BIT0_OE(clk_oe));

	initial forever #20 mclk = ~mclk;
	always @(posedge mclk) if (wdog_rst === 1'b1) wd_n++;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge mclk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge mclk);
		req.rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask : rd
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge mclk);
			lpo_tick <= 1'b1;
			@(posedge mclk);
			lpo_tick <= 1'b0;
		end
	endtask : tick
	task automatic stop_try;
		@(posedge mclk);
		stop_req <= 1'b1;
		@(posedge mclk);
		stop_req <= 1'b0;
		#1;
	endtask : stop_try
	task automatic trig_chk(input logic o, input logic r, input logic i, input logic e);
		@(posedge mclk);
		trig_on <= o;
		rtc_ovf <= r;
		irq_evt <= i;
		repeat (2) @(posedge mclk);
		#1;
		`CHK(conv_trig, e)
	endtask : trig_chk

	// about three and a half times the expected run
	initial begin
		#3000000;
		err_count++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		wr(8'h02, 8'hFF);
		rd(8'h02, {4'h1, PC[11:8]});
		rd(8'h03, PC[7:0]);
		rd(8'h10, 8'h00);
		stop_try();
		`CHK(ill_rst, 1'b1)
		wr(8'h00, 8'h68);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h68);
		`CHK(on_e, 1'b1)
		stop_try();
		`CHK(stop_enter, 1'b1)
		wr(8'h01, 8'h17);
		rd(8'h01, 8'h17);
		wr(8'h01, 8'hC3);
		rd(8'h01, 8'h03);
		`CHK(clk_oe, 1'b1)
		@(posedge clk_out);
		t0 = $time;
		@(negedge clk_out);
		`CHK($time - t0, 64'd120)
		trig_chk(1'b1, 1'b1, 1'b0, 1'b1);
		trig_chk(1'b1, 1'b0, 1'b1, 1'b0);
		wr(8'h01, 8'h10);
		trig_chk(1'b1, 1'b0, 1'b1, 1'b1);
		trig_chk(1'b0, 1'b1, 1'b1, 1'b0);
		`CHK(clk_oe, 1'b0)
		// lpo source, 32 tick period; service in mid-count
		tick(20);
		wr(8'h04, 8'h55);
		wr(8'h04, 8'hAA);
		tick(31);
		`CHK(wd_n, 0)
		tick(1);
		repeat (2) @(posedge mclk);
		`CHK(wd_n, 1)
		wr(8'h04, 8'h12);
		repeat (2) @(posedge mclk);
		`CHK(wd_n, 2)
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		wr(8'h04, 8'h12);
		tick(40);
		`CHK(wd_n, 2)
		// bus source, windowed: early writes must reset
		wr(8'h00, 8'h40);
		wr(8'h01, 8'hC0);
		wr(8'h04, 8'h55);
		repeat (2) @(posedge mclk);
		`CHK(wd_n, 3)
		repeat (6000) @(posedge mclk);
		wr(8'h04, 8'h55);
		repeat (2) @(posedge mclk);
		`CHK(wd_n, 4)
		repeat (6200) @(posedge mclk);
		wr(8'h04, 8'h55);
		wr(8'h04, 8'hAA);
		repeat (8150) @(posedge mclk);
		`CHK(wd_n, 4)
		repeat (80) @(posedge mclk);
		`CHK(wd_n, 5)
		finish_test();
	end
endmodule : test_sowc_cfg
